//--- ssp_pkg.sv
package ssp_pkg;

	// device clock and self-timed waits
	localparam int unsigned CLK_MHZ              = 50;
	localparam int unsigned PAGE_WRITE_WAIT_US   = 4500;
	localparam int unsigned EEPROM_WRITE_WAIT_US = 3600;
	localparam int unsigned ERASE_WAIT_US        = 9000;
	localparam int unsigned FUSE_WRITE_WAIT_US   = 4500;
	localparam int unsigned PAGE_WRITE_WAIT_CYC   = PAGE_WRITE_WAIT_US * CLK_MHZ;
	localparam int unsigned EEPROM_WRITE_WAIT_CYC = EEPROM_WRITE_WAIT_US * CLK_MHZ;
	localparam int unsigned ERASE_WAIT_CYC        = ERASE_WAIT_US * CLK_MHZ;
	localparam int unsigned FUSE_WRITE_WAIT_CYC   = FUSE_WRITE_WAIT_US * CLK_MHZ;
	localparam int unsigned TMR_W                 = 19;

	// array geometry
	localparam int unsigned FL_AW    = 13;
	localparam int unsigned FL_DW    = 16;
	localparam int unsigned PG_AW    = 6;
	localparam int unsigned EE_AW    = 10;
	localparam int unsigned EE_PG_AW = 2;
	localparam int unsigned EE_PG_N  = 4;
	localparam int unsigned WALK_W   = 13;
	localparam logic [WALK_W-1:0] FL_LAST   = 13'h1FFF;
	localparam logic [WALK_W-1:0] EE_DEPTH  = 13'h0400;
	localparam logic [WALK_W-1:0] PG_LAST   = 13'h0040;
	localparam logic [WALK_W-1:0] EE_LAST   = 13'h0003;
	localparam logic [4:0]        BIT_LAST  = 5'h1F;
	localparam logic [1:0]        SLOT_READ = 2'h3;

	// instruction bytes
	localparam logic [7:0] OP_CTRL      = 8'hAC;
	localparam logic [7:0] SUB_ENABLE   = 8'h53;
	localparam logic [7:0] SUB_ERASE    = 8'h80;
	localparam logic [7:0] SUB_FUSE_LO  = 8'hA0;
	localparam logic [7:0] SUB_FUSE_HI  = 8'hA8;
	localparam logic [7:0] SUB_FUSE_EXT = 8'hA4;
	localparam logic [7:0] SUB_LOCK     = 8'hE0;
	localparam logic [7:0] OP_POLL      = 8'hF0;
	localparam logic [7:0] OP_EXT_ADDR  = 8'h4D;
	localparam logic [7:0] OP_LOAD_HI   = 8'h48;
	localparam logic [7:0] OP_LOAD_LO   = 8'h40;
	localparam logic [7:0] OP_EE_LOAD   = 8'hC1;
	localparam logic [7:0] OP_RD_HI     = 8'h28;
	localparam logic [7:0] OP_RD_LO     = 8'h20;
	localparam logic [7:0] OP_RD_EE     = 8'hA0;
	localparam logic [7:0] OP_RD_FL58   = 8'h58;
	localparam logic [7:0] OP_RD_FL50   = 8'h50;
	localparam logic [7:0] SUB_RD_ALT   = 8'h08;
	localparam logic [7:0] OP_RD_SIG    = 8'h30;
	localparam logic [7:0] OP_RD_CAL    = 8'h38;
	localparam logic [7:0] OP_WR_PAGE   = 8'h4C;
	localparam logic [7:0] OP_EE_WR     = 8'hC0;
	localparam logic [7:0] OP_EE_PAGE   = 8'hC2;

	// reset values; signature and calibration values are arbitrary
	localparam logic [7:0] FUSE_LO_RST  = 8'hFF;
	localparam logic [7:0] FUSE_HI_RST  = 8'hFF;
	localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
	localparam logic [7:0] LOCK_RST     = 8'hFF;
	localparam logic [7:0] ERASED_BYTE  = 8'hFF;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	localparam logic [7:0] SIG_0        = 8'h11;
	localparam logic [7:0] SIG_1        = 8'h22;
	localparam logic [7:0] SIG_2        = 8'h33;
	localparam logic [7:0] CAL_BYTE     = 8'h80;

	typedef struct packed {
		logic [7:0] op;
		logic [7:0] arg_hi;
		logic [7:0] arg_lo;
		logic [7:0] data;
	} ssp_frame_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ERASE = 3'b001,
		ST_FPAGE = 3'b010,
		ST_EPAGE = 3'b011,
		ST_WAIT  = 3'b100
	} ssp_state_t;

endpackage

//--- ssp_mem.sv
`timescale 1ns/10ps
module ssp_mem #(
	parameter int unsigned DW = 8,
	parameter int unsigned AW = 6
) (
	// clock
	input  wire  logic          clk,
	// access port
	input  wire  logic          we,
	input  wire  logic [DW-1:0] wmask,
	input  wire  logic [AW-1:0] addr,
	input  wire  logic [DW-1:0] wdata,
	output logic       [DW-1:0] rdata_r
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// masked write keeps unmasked bits; read data registered
	always_ff @(posedge clk)
	begin
		if (we)
			mem[addr] <= (mem[addr] & ~wmask) | (wdata & wmask);
		rdata_r <= mem[addr];
	end
endmodule

//--- ssp_port.sv
`timescale 1ns/10ps
module ssp_port
	import ssp_pkg::*;
#(
	parameter int unsigned PAGE_CYC  = PAGE_WRITE_WAIT_CYC,
	parameter int unsigned EE_CYC    = EEPROM_WRITE_WAIT_CYC,
	parameter int unsigned ERASE_CYC = ERASE_WAIT_CYC,
	parameter int unsigned FUSE_CYC  = FUSE_WRITE_WAIT_CYC
) (
	// clock and reset
	input  wire  logic clk,
	input  wire  logic arst_n,
	// device pins
	input  wire  logic dev_rst_n,
	input  wire  logic sck,
	input  wire  logic mosi,
	output logic       miso,
	output logic       miso_oe,
	// device mode
	output logic       normal_run
);
	logic [1:0]          rst_q;
	logic                rst_n;
	logic [2:0]          sck_q;
	logic [1:0]          mosi_q;
	logic [1:0]          dev_rst_q;
	logic                sck_rise;
	logic                sck_fall;
	logic                session;

	ssp_state_t          state_r, state_nxt;
	logic [TMR_W-1:0]    timer_r, timer_nxt;
	logic [WALK_W-1:0]   walk_r, walk_nxt;
	logic [31:0]         frame_r, frame_nxt;
	logic [4:0]          bitcnt_r, bitcnt_nxt;
	logic [7:0]          tx_r, tx_nxt;
	logic                miso_r, miso_nxt;
	logic                prog_en_r, prog_en_nxt;
	logic                normal_r, normal_nxt;
	logic                oe_r, oe_nxt;
	logic [7:0]          ext_addr_r, ext_addr_nxt;
	logic [7:0]          fuse_lo_r, fuse_lo_nxt;
	logic [7:0]          fuse_hi_r, fuse_hi_nxt;
	logic [7:0]          fuse_ext_r, fuse_ext_nxt;
	logic [7:0]          lock_r, lock_nxt;
	logic [6:0]          page_r, page_nxt;
	logic [7:0]          ee_page_r, ee_page_nxt;
	logic [7:0]          ee_buf_r [EE_PG_N];
	logic [7:0]          ee_buf_nxt [EE_PG_N];
	logic [EE_PG_N-1:0]  ee_ld_r, ee_ld_nxt;

	ssp_frame_t          f;
	logic                frame_done;
	logic                busy;
	logic [7:0]          rd_byte;
	logic [7:0]          out_byte;
	logic                fl_we, ee_we, buf_we;
	logic [FL_DW-1:0]    fl_wdata, fl_rdata, buf_wmask, buf_wdata, buf_rdata;
	logic [FL_AW-1:0]    fl_addr;
	logic [FL_AW-1:0]    wr_word;
	logic [PG_AW-1:0]    buf_addr;
	logic [EE_AW-1:0]    ee_addr;
	logic [7:0]          ee_wdata, ee_rdata;

	function automatic logic [FL_AW-1:0] word_addr(input logic [15:0] a);
		return a[FL_AW-1:0];
	endfunction

	function automatic logic [TMR_W-1:0] wait_cnt(input int unsigned cyc);
		return TMR_W'(cyc);
	endfunction

	// reset release and pin synchronisers
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rst_q <= 2'h0;
		else
			rst_q <= {rst_q[0], 1'b1};
	end
	assign rst_n = rst_q[1];

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sck_q     <= 3'h0;
			mosi_q    <= 2'h0;
			// start as in session so normal_run does not pulse after reset
			dev_rst_q <= 2'h0;
		end
		else
		begin
			sck_q     <= {sck_q[1:0], sck};
			mosi_q    <= {mosi_q[0], mosi};
			dev_rst_q <= {dev_rst_q[0], dev_rst_n};
		end
	end

	assign sck_rise   = sck_q[1] & ~sck_q[2];
	assign sck_fall   = ~sck_q[1] & sck_q[2];
	assign session    = ~dev_rst_q[1];
	assign frame_done = session & sck_rise & (bitcnt_r == BIT_LAST);
	assign f          = ssp_frame_t'({frame_r[30:0], mosi_q[1]});
	assign busy       = (state_r != ST_IDLE);
	assign wr_word    = word_addr({f.arg_hi, f.arg_lo});

	// fourth-byte answer from the three bytes already shifted in
	always_comb
	begin
		rd_byte = 8'h00;
		if (prog_en_r)
		begin
			unique case (frame_r[23:16])
				OP_POLL:    rd_byte = {7'h00, busy};
				OP_RD_HI:   rd_byte = fl_rdata[15:8];
				OP_RD_LO:   rd_byte = fl_rdata[7:0];
				OP_RD_EE:   rd_byte = ee_rdata;
				OP_RD_FL58: rd_byte = (frame_r[15:8] == SUB_RD_ALT) ? fuse_hi_r : lock_r;
				OP_RD_FL50: rd_byte = (frame_r[15:8] == SUB_RD_ALT) ? fuse_ext_r : fuse_lo_r;
				OP_RD_SIG:  rd_byte = (frame_r[1:0] == 2'h0) ? SIG_0 :
						(frame_r[1:0] == 2'h1) ? SIG_1 : SIG_2;
				OP_RD_CAL:  rd_byte = CAL_BYTE;
				default:    rd_byte = 8'h00;
			endcase
		end
	end

	// slots: byte1 out zero, bytes 2 and 3 echo the previous input byte
	assign out_byte = (bitcnt_r[4:3] == SLOT_READ) ? rd_byte :
			(bitcnt_r == 5'h00) ? 8'h00 : frame_r[7:0];

	always_comb
	begin
		state_nxt    = state_r;
		timer_nxt    = (timer_r != '0) ? timer_r - 1'b1 : timer_r;
		walk_nxt     = walk_r;
		frame_nxt    = frame_r;
		bitcnt_nxt   = bitcnt_r;
		tx_nxt       = tx_r;
		miso_nxt     = miso_r;
		prog_en_nxt  = prog_en_r;
		normal_nxt   = ~session;
		oe_nxt       = session;
		ext_addr_nxt = ext_addr_r;
		fuse_lo_nxt  = fuse_lo_r;
		fuse_hi_nxt  = fuse_hi_r;
		fuse_ext_nxt = fuse_ext_r;
		lock_nxt     = lock_r;
		page_nxt     = page_r;
		ee_page_nxt  = ee_page_r;
		ee_buf_nxt   = ee_buf_r;
		ee_ld_nxt    = ee_ld_r;
		fl_we        = 1'b0;
		fl_addr      = word_addr(frame_r[15:0]);
		fl_wdata     = ERASED_WORD;
		buf_we       = 1'b0;
		buf_addr     = walk_r[PG_AW-1:0];
		buf_wmask    = 16'hFFFF;
		buf_wdata    = {f.data, f.data};
		ee_we        = 1'b0;
		ee_addr      = {frame_r[9:8], frame_r[7:0]};
		ee_wdata     = f.data;

		if (!session)
		begin
			// reset high: leave programming, resync the frame
			prog_en_nxt = 1'b0;
			bitcnt_nxt  = 5'h00;
			frame_nxt   = 32'h0;
		end
		else
		begin
			if (sck_rise)
			begin
				frame_nxt  = {frame_r[30:0], mosi_q[1]};
				bitcnt_nxt = bitcnt_r + 5'h01;
			end
			if (sck_fall)
			begin
				if (bitcnt_r[2:0] == 3'h0)
				begin
					miso_nxt = out_byte[7];
					tx_nxt   = {out_byte[6:0], 1'b0};
				end
				else
				begin
					miso_nxt = tx_r[7];
					tx_nxt   = {tx_r[6:0], 1'b0};
				end
			end
		end

		if (frame_done)
		begin
			if (f.op == OP_CTRL && f.arg_hi == SUB_ENABLE)
				prog_en_nxt = 1'b1;
			else if (prog_en_r)
			begin
				unique case (f.op)
					OP_EXT_ADDR: ext_addr_nxt = f.arg_lo;
					OP_CTRL:
						if (!busy)
						begin
							if (f.arg_hi == SUB_ERASE)
							begin
								state_nxt = ST_ERASE;
								walk_nxt  = '0;
								timer_nxt = wait_cnt(ERASE_CYC);
								lock_nxt  = LOCK_RST;
							end
							else if (f.arg_hi == SUB_FUSE_LO || f.arg_hi == SUB_FUSE_HI ||
									f.arg_hi == SUB_FUSE_EXT || f.arg_hi == SUB_LOCK)
							begin
								state_nxt = ST_WAIT;
								timer_nxt = wait_cnt(FUSE_CYC);
								if (f.arg_hi == SUB_FUSE_LO)
									fuse_lo_nxt = f.data;
								else if (f.arg_hi == SUB_FUSE_HI)
									fuse_hi_nxt = f.data;
								else if (f.arg_hi == SUB_FUSE_EXT)
									fuse_ext_nxt = f.data;
								else
									lock_nxt = lock_r & f.data;
							end
						end
					OP_LOAD_LO, OP_LOAD_HI:
						if (!busy)
						begin
							buf_we    = 1'b1;
							buf_addr  = f.arg_lo[PG_AW-1:0];
							buf_wmask = (f.op == OP_LOAD_LO) ? 16'h00FF : 16'hFF00;
						end
					OP_WR_PAGE:
						if (!busy)
						begin
							page_nxt  = wr_word[FL_AW-1:PG_AW];
							state_nxt = ST_FPAGE;
							walk_nxt  = '0;
							timer_nxt = wait_cnt(PAGE_CYC);
						end
					OP_EE_WR:
						if (!busy)
						begin
							ee_we     = 1'b1;
							ee_addr   = {f.arg_hi[1:0], f.arg_lo};
							state_nxt = ST_WAIT;
							timer_nxt = wait_cnt(EE_CYC);
						end
					OP_EE_LOAD:
						if (!busy)
						begin
							ee_buf_nxt[f.arg_lo[EE_PG_AW-1:0]] = f.data;
							ee_ld_nxt[f.arg_lo[EE_PG_AW-1:0]]  = 1'b1;
						end
					OP_EE_PAGE:
						if (!busy)
						begin
							ee_page_nxt = {f.arg_hi[1:0], f.arg_lo[7:2]};
							state_nxt   = ST_EPAGE;
							walk_nxt    = '0;
							timer_nxt   = wait_cnt(EE_CYC);
						end
					default: ;
				endcase
			end
		end

		unique case (state_r)
			ST_IDLE: ;
			ST_ERASE:
			begin
				fl_we    = 1'b1;
				fl_addr  = walk_r[FL_AW-1:0];
				ee_we    = (walk_r < EE_DEPTH);
				ee_addr  = walk_r[EE_AW-1:0];
				ee_wdata = ERASED_BYTE;
				walk_nxt = walk_r + 1'b1;
				if (walk_r == FL_LAST)
					state_nxt = ST_WAIT;
			end
			ST_FPAGE:
			begin
				// buffer read data lags its address by one cycle
				fl_we    = (walk_r != '0);
				fl_addr  = {page_r, walk_r[PG_AW-1:0] - 1'b1};
				fl_wdata = buf_rdata;
				walk_nxt = walk_r + 1'b1;
				if (walk_r == PG_LAST)
					state_nxt = ST_WAIT;
			end
			ST_EPAGE:
			begin
				ee_we    = ee_ld_r[walk_r[EE_PG_AW-1:0]];
				ee_addr  = {ee_page_r, walk_r[EE_PG_AW-1:0]};
				ee_wdata = ee_buf_r[walk_r[EE_PG_AW-1:0]];
				walk_nxt = walk_r + 1'b1;
				if (walk_r == EE_LAST)
				begin
					state_nxt = ST_WAIT;
					ee_ld_nxt = '0;
				end
			end
			ST_WAIT:
				if (timer_r == '0)
					state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r    <= ST_IDLE;
			timer_r    <= '0;
			walk_r     <= '0;
			frame_r    <= 32'h0;
			bitcnt_r   <= 5'h00;
			tx_r       <= 8'h00;
			miso_r     <= 1'b0;
			prog_en_r  <= 1'b0;
			normal_r   <= 1'b0;
			oe_r       <= 1'b1;
			ext_addr_r <= 8'h00;
			fuse_lo_r  <= FUSE_LO_RST;
			fuse_hi_r  <= FUSE_HI_RST;
			fuse_ext_r <= FUSE_EXT_RST;
			lock_r     <= LOCK_RST;
			page_r     <= 7'h00;
			ee_page_r  <= 8'h00;
			ee_buf_r   <= '{default: 8'h00};
			ee_ld_r    <= '0;
		end
		else
		begin
			state_r    <= state_nxt;
			timer_r    <= timer_nxt;
			walk_r     <= walk_nxt;
			frame_r    <= frame_nxt;
			bitcnt_r   <= bitcnt_nxt;
			tx_r       <= tx_nxt;
			miso_r     <= miso_nxt;
			prog_en_r  <= prog_en_nxt;
			normal_r   <= normal_nxt;
			oe_r       <= oe_nxt;
			ext_addr_r <= ext_addr_nxt;
			fuse_lo_r  <= fuse_lo_nxt;
			fuse_hi_r  <= fuse_hi_nxt;
			fuse_ext_r <= fuse_ext_nxt;
			lock_r     <= lock_nxt;
			page_r     <= page_nxt;
			ee_page_r  <= ee_page_nxt;
			ee_buf_r   <= ee_buf_nxt;
			ee_ld_r    <= ee_ld_nxt;
		end
	end

	assign miso       = miso_r;
	assign miso_oe    = oe_r;
	assign normal_run = normal_r;

	ssp_mem #(.DW(FL_DW), .AW(FL_AW)) u_flash (
		.clk     (clk),
		.we      (fl_we),
		.wmask   (16'hFFFF),
		.addr    (fl_addr),
		.wdata   (fl_wdata),
		.rdata_r (fl_rdata)
	);

	ssp_mem #(.DW(FL_DW), .AW(PG_AW)) u_page_buf (
		.clk     (clk),
		.we      (buf_we),
		.wmask   (buf_wmask),
		.addr    (buf_addr),
		.wdata   (buf_wdata),
		.rdata_r (buf_rdata)
	);

	ssp_mem #(.DW(8), .AW(EE_AW)) u_eeprom (
		.clk     (clk),
		.we      (ee_we),
		.wmask   (8'hFF),
		.addr    (ee_addr),
		.wdata   (ee_wdata),
		.rdata_r (ee_rdata)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_erase_cmd;
		frame_done && prog_en_r && !busy && f.op == OP_CTRL && f.arg_hi == SUB_ERASE;
	endsequence

	a_gate_no_write: assert property (!prog_en_r && !busy |-> !fl_we && !ee_we && !buf_we)
		else $error("memory written before enable");
	a_sample_rise: assert property (session && sck_rise |=> bitcnt_r == $past(bitcnt_r) + 5'h01)
		else $error("bit not taken on rising edge");
	a_miso_fall: assert property ($changed(miso_r) |-> $past(sck_fall))
		else $error("miso changed away from falling edge");
	a_echo_third: assert property (session && sck_fall && bitcnt_r == 5'h10
			|=> miso_r == $past(frame_r[7]))
		else $error("second byte not echoed");
	a_enable_take: assert property (frame_done && f.op == OP_CTRL
			&& f.arg_hi == SUB_ENABLE |=> prog_en_r)
		else $error("enable not taken");
	a_erase_walk: assert property (s_erase_cmd |=> state_r == ST_ERASE ##1
			(fl_we && fl_wdata == ERASED_WORD && ee_wdata == ERASED_BYTE))
		else $error("erase does not fill with ones");
	a_busy_report: assert property (session && sck_fall && bitcnt_r == 5'h18
			&& busy && prog_en_r && frame_r[23:16] == OP_POLL |=> tx_r[1])
		else $error("poll misses busy");
	a_busy_hold: assert property (state_r == ST_WAIT && timer_r != '0 |=> state_r == ST_WAIT)
		else $error("wait left early");
	a_leave_run: assert property (!session |=> normal_r && !prog_en_r && bitcnt_r == 5'h00)
		else $error("session not left on reset high");
	a_ext_latch: assert property (frame_done && prog_en_r && f.op == OP_EXT_ADDR
			|=> ext_addr_r == $past(f.arg_lo))
		else $error("extension byte not latched");
endmodule

//--- ssp_prog.sv
`timescale 1ns/10ps
module ssp_prog
	import ssp_pkg::*;
#(
	parameter int unsigned HALF_CYC   = 4,
	parameter int unsigned SETTLE_CYC = 16
) (
	// clock
	input  wire logic clk,
	// device pins
	output logic      dev_rst_n,
	output logic      sck,
	output logic      mosi,
	input  wire logic miso
);
	initial
	begin
		dev_rst_n = 1'b0;
		sck       = 1'b0;
		mosi      = 1'b0;
	end

	task automatic set_reset(input logic v);
		@(posedge clk);
		dev_rst_n <= v;
	endtask

	// mode 0, msb first; each answer bit is taken as its own clock pulse ends
	task automatic frame(input ssp_frame_t d, output ssp_frame_t r);
		logic [31:0] v;
		logic [31:0] q;
		v = d;
		@(posedge clk);
		for (int i = 31; i >= 0; i--)
		begin
			mosi <= v[i];
			repeat (HALF_CYC) @(posedge clk);
			sck <= 1'b1;
			repeat (HALF_CYC) @(posedge clk);
			q[i] = miso;
			sck <= 1'b0;
		end
		r = q;
	endtask

	// settling wait shortened, the block does not time it
	task automatic enable(output logic ok);
		ssp_frame_t r;
		ok = 1'b0;
		repeat (SETTLE_CYC) @(posedge clk);
		for (int t = 0; t < 3 && ok !== 1'b1; t++)
		begin
			frame({OP_CTRL, SUB_ENABLE, 8'h00, 8'h00}, r);
			ok = (r.arg_lo === SUB_ENABLE);
			if (ok !== 1'b1)
			begin
				set_reset(1'b1);
				repeat (3) @(posedge clk);
				set_reset(1'b0);
				repeat (8) @(posedge clk);
			end
		end
	endtask

	task automatic poll(input int unsigned lim, output int unsigned n);
		ssp_frame_t r;
		n = 0;
		r = '1;
		while (r.data[0] !== 1'b0 && n < lim)
		begin
			frame({OP_POLL, 24'h000000}, r);
			n++;
		end
	endtask
endmodule

//--- ssp_port_bench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) \
	begin \
		checked++; \
		if ((g) !== (e)) \
		begin \
			errors++; \
			$display("ERROR %s expected %0h seen %0h", nm, e, g); \
		end \
	end
module ssp_port_bench
	import ssp_pkg::*;
;
	localparam int unsigned WR_CYC = 1200;
	localparam int unsigned ER_CYC = 9000;
	logic clk;
	logic arst_n;
	logic dev_rst_n;
	logic sck;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic normal_run;
	int   errors;
	int   checked;

	ssp_port #(
		.PAGE_CYC  (WR_CYC),
		.EE_CYC    (WR_CYC),
		.ERASE_CYC (ER_CYC),
		.FUSE_CYC  (WR_CYC)
	) ssp_port_i (
		.clk        (clk),
		.arst_n     (arst_n),
		.dev_rst_n  (dev_rst_n),
		.sck        (sck),
		.mosi       (mosi),
		.miso       (miso),
		.miso_oe    (miso_oe),
		.normal_run (normal_run)
	);

	ssp_prog ssp_prog_i (
		.clk       (clk),
		.dev_rst_n (dev_rst_n),
		.sck       (sck),
		.mosi      (mosi),
		.miso      (miso)
	);

	initial
		clk = 1'b0;
	always #10 clk = ~clk;

	task automatic xfer(input logic [31:0] f, output logic [7:0] q);
		ssp_frame_t r;
		ssp_prog_i.frame(f, r);
		q = r.data;
	endtask

	task automatic rd(input logic [31:0] f, input logic [7:0] e, input string nm);
		logic [7:0] q;
		xfer(f, q);
		`CHK(nm, e, q)
	endtask

	// send, then poll until idle
	task automatic wr(input logic [31:0] f, output int unsigned n);
		logic [7:0] q;
		xfer(f, q);
		ssp_prog_i.poll(60, n);
		`CHK("idle after write", 1'b1, n < 60)
	endtask

	task automatic done(input string nm);
		$display("test %s done, mismatches so far %0d", nm, errors);
	endtask

	task automatic t_session;
		logic        ok;
		logic [7:0]  q;
		int unsigned n;
		`CHK("session mode", 1'b0, normal_run)
		ssp_prog_i.enable(ok);
		`CHK("enable echo", 1'b1, ok)
		`CHK("miso driven", 1'b1, miso_oe)
		wr({OP_CTRL, SUB_ERASE, 16'h0000}, n);
		`CHK("erase busy", 1'b1, n > 1)
		rd({OP_RD_LO, 16'h1FFF, 8'h00}, ERASED_BYTE, "flash low");
		rd({OP_RD_HI, 16'h0000, 8'h00}, ERASED_BYTE, "flash high");
		rd({OP_RD_EE, 16'h03FF, 8'h00}, ERASED_BYTE, "eeprom");
		ssp_prog_i.set_reset(1'b1);
		repeat (8) @(posedge clk);
		`CHK("normal run", 1'b1, normal_run)
		`CHK("miso released", 1'b0, miso_oe)
		ssp_prog_i.set_reset(1'b0);
		repeat (8) @(posedge clk);
		xfer({OP_EE_WR, 16'h0005, 8'h12}, q);
		repeat (WR_CYC) @(posedge clk);
		ssp_prog_i.enable(ok);
		`CHK("re-enable", 1'b1, ok)
		rd({OP_RD_EE, 16'h0005, 8'h00}, ERASED_BYTE, "locked write");
		done("session");
	endtask

	task automatic t_flash;
		logic [7:0]  q;
		int unsigned n;
		xfer({OP_EXT_ADDR, 16'h0001, 8'h00}, q);
		xfer({OP_LOAD_LO, 16'h0000, 8'h3C}, q);
		xfer({OP_LOAD_HI, 16'h0000, 8'hA1}, q);
		xfer({OP_LOAD_LO, 16'h003F, 8'h5E}, q);
		xfer({OP_LOAD_HI, 16'h003F, 8'h07}, q);
		wr({OP_WR_PAGE, 16'h0040, 8'h00}, n);
		rd({OP_RD_LO, 16'h0040, 8'h00}, 8'h3C, "word 40 low");
		rd({OP_RD_HI, 16'h0040, 8'h00}, 8'hA1, "word 40 high");
		rd({OP_RD_LO, 16'h007F, 8'h00}, 8'h5E, "word 7F low");
		rd({OP_RD_HI, 16'h007F, 8'h00}, 8'h07, "word 7F high");
		rd({OP_RD_LO, 16'h0000, 8'h00}, ERASED_BYTE, "other page");
		done("flash");
	endtask

	task automatic t_eeprom;
		logic [7:0]  q;
		int unsigned n;
		xfer({OP_EE_WR, 16'h03FF, 8'hA5}, q);
		xfer({OP_EE_WR, 16'h03FF, 8'h5A}, q);
		ssp_prog_i.poll(60, n);
		`CHK("write busy", 1'b1, n > 1)
		rd({OP_RD_EE, 16'h03FF, 8'h00}, 8'hA5, "ee busy refuse");
		wr({OP_EE_WR, 16'h03FF, 8'h5A}, n);
		rd({OP_RD_EE, 16'h03FF, 8'h00}, 8'h5A, "ee auto erase");
		wr({OP_EE_WR, 16'h0012, 8'h77}, n);
		xfer({OP_EE_LOAD, 16'h0001, 8'h5A}, q);
		wr({OP_EE_PAGE, 16'h0010, 8'h00}, n);
		rd({OP_RD_EE, 16'h0011, 8'h00}, 8'h5A, "ee page loaded");
		rd({OP_RD_EE, 16'h0012, 8'h00}, 8'h77, "ee page kept");
		rd({OP_RD_EE, 16'h0010, 8'h00}, ERASED_BYTE, "ee page blank");
		done("eeprom");
	endtask

	task automatic t_fuse;
		logic [7:0]  sub [4] = '{SUB_FUSE_LO, SUB_FUSE_HI, SUB_FUSE_EXT, SUB_LOCK};
		logic [7:0]  rop [4] = '{OP_RD_FL50, OP_RD_FL58, OP_RD_FL50, OP_RD_FL58};
		logic [7:0]  rsb [4] = '{8'h00, SUB_RD_ALT, SUB_RD_ALT, 8'h00};
		logic [7:0]  val [4] = '{8'hE2, 8'hD9, 8'hFD, 8'hFC};
		int unsigned n;
		for (int k = 0; k < 4; k++)
		begin
			wr({OP_CTRL, sub[k], 8'h00, val[k]}, n);
			rd({rop[k], rsb[k], 16'h0000}, val[k], "fuse or lock");
		end
		rd({OP_RD_FL50, 24'h000000}, 8'hE2, "low fuse kept");
		done("fuse");
	endtask

	task automatic t_ident;
		logic [7:0] sig [3] = '{SIG_0, SIG_1, SIG_2};
		for (int k = 0; k < 3; k++)
			rd({OP_RD_SIG, 8'h00, 8'(k), 8'h00}, sig[k], "signature");
		rd({OP_RD_CAL, 24'h000000}, CAL_BYTE, "calibration");
		done("ident");
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		arst_n  = 1'b0;
		errors  = 0;
		checked = 0;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		repeat (8) @(posedge clk);
		t_session;
		t_flash;
		t_eeprom;
		t_fuse;
		t_ident;
		end_of_test;
	end

	// the sequence needs about 33000 cycles
	initial
	begin
		repeat (90000) @(posedge clk);
		errors++;
		$display("ERROR watchdog expected done seen hang");
		end_of_test;
	end
endmodule
